// ===== hdl/sag_pkg.sv
/*
 * package for the safe and/or combining block: state codes, widths,
 * reset values and the neutral identity code.
 * assumes nothing of its surroundings.
 */
package sag_pkg;

    localparam int NUM_INPUTS = 8;
    localparam int STATE_W = 8;
    localparam int DIAG_W = 16;

    // state codes as reported on the state word
    localparam logic [7:0] STATE_UNDEF = 8'h00;
    localparam logic [7:0] STATE_RUN = 8'h01;
    localparam logic [7:0] STATE_STOP = 8'h02;
    localparam logic [7:0] STATE_SAFE = 8'h03;

    localparam logic [15:0] DIAG_VALUE = 16'h0000;
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam logic [7:0] INVERT_RESET = 8'h00;

    // gate variant selection
    localparam logic GATE_AND = 1'b0;
    localparam logic GATE_OR = 1'b1;

    // identity code; value is arbitrary
    localparam logic [15:0] BLOCK_ID = 16'h0a10;

    typedef enum logic [1:0] {
        SAG_RUN,
        SAG_STOP,
        SAG_SAFE
    } sag_state_t;

endpackage : sag_pkg

// ===== hdl/sag_combine.sv
/*
 * combinational core: inversion, enable masking and and/or combining
 * of eight single channels.
 * assumes synchronised inputs from the parent.
 */
`timescale 1ns/1ps
module sag_combine #(
    parameter int N = 8
) (
    // channel data and configuration
    input wire logic [N-1:0] chanIn,
    input wire logic [N-1:0] chanEnable,
    input wire logic [N-1:0] chanInvert,
    input wire logic gateSel,
    // result
    output logic gateResult
);
    logic [N-1:0] chanEff;

    // inverted channels are negated before combining
    assign chanEff = chanIn ^ chanInvert;

    always_comb begin
        if (gateSel == sag_pkg::GATE_AND) begin
            // disabled channels act as 1, so they never block
            // with no channel enabled the and stays low (not configured)
            gateResult = (|chanEnable) && &(chanEff | ~chanEnable);
        end else begin
            // disabled channels act as 0
            gateResult = |(chanEff & chanEnable);
        end
    end

endmodule : sag_combine

// ===== hdl/sag_gate.sv
/*
 * safe and/or combining block: eight single channels, per-channel enable
 * and inversion, registered result, state word and zero diagnostic word.
 * assumes channel inputs and run request may come from other domains;
 * configuration comes from logic on clk and is held static in use.
 */
`timescale 1ns/1ps

module sag_gate #(
    parameter int N = sag_pkg::NUM_INPUTS
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // channel inputs from safe channels or other blocks
    input wire logic [N-1:0] chanIn,
    input wire logic blockRunRequest,
    // configuration, on clk
    input wire logic gateSel,
    input wire logic [N-1:0] cfgEnable,
    input wire logic [N-1:0] cfgInvert,
    input wire logic cfgLoad,
    input wire logic mapStateEn,
    input wire logic mapDiagEn,
    // result and information
    output logic gateResult_q,
    output logic [7:0] stateCode_q,
    output logic [15:0] diagWord_q,
    output logic errorOut_q,
    // process image copies
    output logic [7:0] imageState_q,
    output logic [15:0] imageDiag_q,
    output logic imageStateValid_q,
    output logic imageDiagValid_q
);
    logic [N-1:0] chanMeta_q;
    logic [N-1:0] chanSync_q;
    logic runMeta_q;
    logic runSync_q;
    logic [N-1:0] enable_q;
    logic [N-1:0] invert_q;
    logic combined;
    sag_pkg::sag_state_t state_d;
    sag_pkg::sag_state_t state_q;
    logic [7:0] stateCode_d;
    logic [1:0] syncFill_q;

    function automatic logic [7:0] encode_state(sag_pkg::sag_state_t s);
        unique case (s)
            sag_pkg::SAG_RUN: encode_state = sag_pkg::STATE_RUN;
            sag_pkg::SAG_STOP: encode_state = sag_pkg::STATE_STOP;
            sag_pkg::SAG_SAFE: encode_state = sag_pkg::STATE_SAFE;
        endcase
    endfunction : encode_state

    // two-stage synchronisers; each channel stands alone, so no
    // discrepancy or timing check between channels exists
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            chanMeta_q <= '0;
            chanSync_q <= '0;
            runMeta_q <= 1'b0;
            runSync_q <= 1'b0;
        end else begin
            chanMeta_q <= chanIn;
            chanSync_q <= chanMeta_q;
            runMeta_q <= blockRunRequest;
            runSync_q <= runMeta_q;
        end
    end

    // configuration store; every channel starts disabled
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            enable_q <= N'(sag_pkg::ENABLE_RESET);
            invert_q <= N'(sag_pkg::INVERT_RESET);
        end else if (cfgLoad) begin
            enable_q <= cfgEnable;
            invert_q <= cfgInvert;
        end
    end

    // the first and input may carry a standard signal; the design relies
    // on the configurer enabling a second, safe input so a standard
    // signal can only release the output
    sag_combine #(
        .N(N)
    ) u_combine (
        .chanIn(chanSync_q),
        .chanEnable(enable_q),
        .chanInvert(invert_q),
        .gateSel(gateSel),
        .gateResult(combined)
    );

    // run request low overrides everything
    always_comb begin
        if (!runSync_q) begin
            state_d = sag_pkg::SAG_STOP;
        end else if (combined) begin
            state_d = sag_pkg::SAG_RUN;
        end else begin
            state_d = sag_pkg::SAG_SAFE;
        end
    end

    assign stateCode_d = encode_state(state_d);

    // evaluated every cycle, reset to stop with the output low
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= sag_pkg::SAG_STOP;
            stateCode_q <= sag_pkg::STATE_STOP;
            gateResult_q <= 1'b0;
        end else begin
            state_q <= state_d;
            stateCode_q <= stateCode_d;
            gateResult_q <= (state_d == sag_pkg::SAG_RUN);
        end
    end

    // diagnostic and error are constant but kept as flops so every
    // output leaves a register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            diagWord_q <= sag_pkg::DIAG_VALUE;
            errorOut_q <= 1'b0;
        end else begin
            diagWord_q <= sag_pkg::DIAG_VALUE;
            errorOut_q <= 1'b0;
        end
    end

    // process image copies; unmapped fields read zero
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            imageState_q <= sag_pkg::STATE_UNDEF;
            imageStateValid_q <= 1'b0;
        end else begin
            imageStateValid_q <= mapStateEn;
            imageState_q <= mapStateEn ? stateCode_d : sag_pkg::STATE_UNDEF;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            imageDiag_q <= sag_pkg::DIAG_VALUE;
            imageDiagValid_q <= 1'b0;
        end else begin
            imageDiagValid_q <= mapDiagEn;
            imageDiag_q <= sag_pkg::DIAG_VALUE;
        end
    end

    // sync fill marker: both stages hold post-reset samples only from the
    // second edge after release, so latency checks wait for it
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            syncFill_q <= 2'h0;
        end else begin
            syncFill_q <= {syncFill_q[0], 1'b1};
        end
    end

    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence runDrops;
        !runSync_q;
    endsequence

    sequence allEnHigh;
        runSync_q && gateSel == sag_pkg::GATE_AND && (|enable_q)
            && &((chanSync_q ^ invert_q) | ~enable_q);
    endsequence

    sequence anyEnHigh;
        runSync_q && gateSel == sag_pkg::GATE_OR
            && |((chanSync_q ^ invert_q) & enable_q);
    endsequence

    sequence orAllLow;
        runSync_q && gateSel == sag_pkg::GATE_OR
            && !(|((chanSync_q ^ invert_q) & enable_q));
    endsequence

    sequence syncFull;
        syncFill_q == 2'h3;
    endsequence

    sequence runRises;
        !runSync_q ##1 runSync_q;
    endsequence

    sequence noneEnabled;
        runSync_q && enable_q == '0;
    endsequence

    sequence cfgStrobe;
        cfgLoad;
    endsequence

    sequence runDropsTwice;
        runDrops ##1 runDrops;
    endsequence

    and_run_a: assert property (allEnHigh |=>
        stateCode_q == 8'h01 && gateResult_q)
        else $error("and run not reported");
    stop_forced_a: assert property (runDrops |=>
        stateCode_q == 8'h02 && !gateResult_q)
        else $error("stop not forced");
    and_safe_a: assert property (runSync_q && gateSel == sag_pkg::GATE_AND
        && (|(~(chanSync_q ^ invert_q) & enable_q)) |=>
        stateCode_q == 8'h03 && !gateResult_q)
        else $error("and safe not reported");
    or_run_a: assert property (anyEnHigh |=>
        stateCode_q == 8'h01 && gateResult_q)
        else $error("or run not reported");
    or_safe_a: assert property (runSync_q && gateSel == sag_pkg::GATE_OR
        && !(|((chanSync_q ^ invert_q) & enable_q)) |=>
        stateCode_q == 8'h03 && !gateResult_q)
        else $error("or safe not reported");
    output_state_a: assert property (
        gateResult_q == (stateCode_q == 8'h01) && stateCode_q != 8'h00
        && stateCode_q <= 8'h03)
        else $error("output and state disagree");
    diag_zero_a: assert property (diagWord_q == 16'h0000
        && imageDiag_q == 16'h0000 && !errorOut_q)
        else $error("diag or error not zero");
    image_copy_a: assert property (mapStateEn ##1 1'b1 |->
        imageState_q == stateCode_q && imageStateValid_q)
        else $error("state not copied to image");
    cfg_hold_a: assert property (!cfgLoad |=>
        enable_q == $past(enable_q) && invert_q == $past(invert_q))
        else $error("configuration changed without load");

    // latency and bookkeeping checks
    chan_sync_a: assert property (syncFull |->
        chanSync_q == $past(chanIn, 2))
        else $error("channel sync latency wrong");
    run_sync_a: assert property (syncFull |->
        runSync_q == $past(blockRunRequest, 2))
        else $error("run request sync latency wrong");
    meta_chain_a: assert property (1'b1 |=>
        chanSync_q == $past(chanMeta_q) && runSync_q == $past(runMeta_q))
        else $error("synchroniser stages out of step");
    state_reg_a: assert property (
        stateCode_q == encode_state(state_q))
        else $error("state code and state disagree");
    state_step_a: assert property (1'b1 |=>
        state_q == $past(state_d))
        else $error("state not updated every cycle");
    combine_match_a: assert property (1'b1 |=>
        gateResult_q == ($past(runSync_q) && $past(combined)))
        else $error("output does not follow combined result");

    // recovery from stop, the unconfigured case and the constant error and diag words
    run_leaves_stop_a: assert property (runRises |=>
        stateCode_q != sag_pkg::STATE_STOP)
        else $error("stop kept after run request");
    stop_held_a: assert property (runDropsTwice |=>
        stateCode_q == sag_pkg::STATE_STOP && !gateResult_q)
        else $error("stop not held while run low");
    none_enabled_a: assert property (noneEnabled |=>
        stateCode_q == sag_pkg::STATE_SAFE && !gateResult_q)
        else $error("unconfigured block left safe state");
    error_hold_a: assert property (1'b1 |=>
        $stable(errorOut_q) && $stable(diagWord_q))
        else $error("error or diag word moved");

    // configuration and process image
    cfg_load_a: assert property (cfgStrobe |=>
        enable_q == $past(cfgEnable) && invert_q == $past(cfgInvert))
        else $error("configuration not stored on load");
    image_valid_a: assert property (1'b1 |=>
        imageDiagValid_q == $past(mapDiagEn)
        && imageStateValid_q == $past(mapStateEn))
        else $error("image valid flags lag wrong");
    image_unmap_a: assert property (!mapStateEn |=>
        imageState_q == sag_pkg::STATE_UNDEF)
        else $error("unmapped image state not zero");
    image_state_a: assert property (mapStateEn |=>
        imageState_q != sag_pkg::STATE_UNDEF)
        else $error("mapped image state reads undefined");
    or_safe_image_a: assert property (orAllLow ##0 mapStateEn |=>
        imageState_q == sag_pkg::STATE_SAFE)
        else $error("or safe state not copied to image");

endmodule : sag_gate

// ===== verif/sag_src_model.sv
/*
 * partner model: the safe input channels and upstream blocks that feed
 * the gate channels.
 * assumes clk and nrst from the bench, levels set by the bench.
 */
`timescale 1ns/1ps
module sag_src_model (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // wanted channel levels
    input wire logic [7:0] level,
    // channel lines
    output logic [7:0] chanIn
);
    // channel 0 may stand for a standard source, the rest are safe;
    // a source held in reset reads low, like an opened contact
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            chanIn <= 8'h00;
        end else begin
            chanIn <= level;
        end
    end
endmodule : sag_src_model

// ===== verif/tb_sag_gate.sv
/*
 * self-checking bench for the combining block: reset and zero-enable
 * checks, then table of cases, unmapped image and mid-run reset checks.
 * assumes the design's three-edge input latency plus one model edge.
 */
`timescale 1ns/1ps
module tb_sag_gate;
    typedef struct packed {
        logic s;
        logic [7:0] en;
        logic [7:0] inv;
        logic [7:0] ch;
        logic run;
        logic res;
        logic [7:0] st;
    } sag_row_t;
    // every and row enables two channels or more
    localparam sag_row_t ROWS [10] = '{
        '{1'b0, 8'h03, 8'h00, 8'h03, 1'b1, 1'b1, 8'h01},
        '{1'b0, 8'h03, 8'h00, 8'h01, 1'b1, 1'b0, 8'h03},
        '{1'b0, 8'hff, 8'h00, 8'hff, 1'b0, 1'b0, 8'h02},
        '{1'b0, 8'h03, 8'h02, 8'h01, 1'b1, 1'b1, 8'h01},
        '{1'b0, 8'h81, 8'h00, 8'h81, 1'b1, 1'b1, 8'h01},
        '{1'b1, 8'h0c, 8'h00, 8'h04, 1'b1, 1'b1, 8'h01},
        '{1'b1, 8'h0c, 8'h00, 8'h00, 1'b1, 1'b0, 8'h03},
        '{1'b1, 8'hff, 8'h00, 8'hff, 1'b0, 1'b0, 8'h02},
        '{1'b1, 8'h0c, 8'h0c, 8'h0c, 1'b1, 1'b0, 8'h03},
        '{1'b1, 8'h01, 8'h00, 8'hfe, 1'b1, 1'b0, 8'h03}};
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] level = 8'h00;
    logic [7:0] chanIn;
    logic blockRunRequest = 1'b0;
    logic gateSel = 1'b0;
    logic [7:0] cfgEnable = 8'h00;
    logic [7:0] cfgInvert = 8'h00;
    logic cfgLoad = 1'b0;
    logic mapStateEn = 1'b1;
    logic mapDiagEn = 1'b1;
    logic gateResult_q;
    logic [7:0] stateCode_q;
    logic [15:0] diagWord_q;
    logic errorOut_q;
    logic [7:0] imageState_q;
    logic [15:0] imageDiag_q;
    logic imageStateValid_q;
    logic imageDiagValid_q;
    int errCount = 0;
    int nCompared = 0;
    int cycles = 0;

    sag_src_model src (.clk(clk), .nrst(nrst), .level(level),
        .chanIn(chanIn));
    sag_gate dut (.clk(clk), .nrst(nrst), .chanIn(chanIn),
        .blockRunRequest(blockRunRequest), .gateSel(gateSel),
        .cfgEnable(cfgEnable), .cfgInvert(cfgInvert), .cfgLoad(cfgLoad),
        .mapStateEn(mapStateEn), .mapDiagEn(mapDiagEn),
        .gateResult_q(gateResult_q), .stateCode_q(stateCode_q),
        .diagWord_q(diagWord_q), .errorOut_q(errorOut_q),
        .imageState_q(imageState_q), .imageDiag_q(imageDiag_q),
        .imageStateValid_q(imageStateValid_q),
        .imageDiagValid_q(imageDiagValid_q));

    initial begin
        forever #25 clk = ~clk;
    end

    task automatic print_verdict;
        $display("compared %0d, mismatches %0d", nCompared, errCount);
        if (errCount == 0 && nCompared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        nCompared++;
        if (seen !== exp) begin
            errCount++;
            $display("MISMATCH at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : chk

    // a hang of the run counts against it
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            errCount++;
            print_verdict();
        end
    end

    // load config and levels, then let model, sync and output settle
    task automatic apply(input sag_row_t r);
        @(posedge clk);
        gateSel <= r.s;
        cfgEnable <= r.en;
        cfgInvert <= r.inv;
        cfgLoad <= 1'b1;
        level <= r.ch;
        blockRunRequest <= r.run;
        @(posedge clk);
        cfgLoad <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
    endtask : apply

    initial begin
        repeat (7) @(posedge clk);
        #1;
        chk(16'(stateCode_q), 16'h0002);
        chk({diagWord_q[14:0], gateResult_q}, 16'h0000);
        // release on the eighth edge
        @(posedge clk);
        nrst <= 1'b1;
        // configuration left at reset: no channel takes part
        level <= 8'h00;
        blockRunRequest <= 1'b1;
        // run request still in the synchroniser: stop for two edges
        repeat (2) @(posedge clk);
        #1;
        chk(16'(stateCode_q), 16'h0002);
        repeat (4) @(posedge clk);
        #1;
        chk(16'(stateCode_q), 16'h0003);
        $display("reset test done");
        foreach (ROWS[i]) begin
            apply(ROWS[i]);
            chk(16'(gateResult_q), 16'(ROWS[i].res));
            chk(16'(stateCode_q), 16'(ROWS[i].st));
            chk(diagWord_q, 16'h0000);
            chk(16'(errorOut_q), 16'h0000);
            chk(16'(imageState_q), 16'(ROWS[i].st));
            chk(imageDiag_q, 16'h0000);
            chk(16'({imageStateValid_q, imageDiagValid_q}), 16'h0003);
            $display("row %0d done", i);
        end
        @(posedge clk);
        mapStateEn <= 1'b0;
        mapDiagEn <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk(16'(imageState_q), 16'h0000);
        chk(16'({imageStateValid_q, imageDiagValid_q}), 16'h0000);
        $display("unmapped test done");
        apply(ROWS[0]);
        @(posedge clk);
        nrst <= 1'b0;
        #1;
        chk(16'(stateCode_q), 16'h0002);
        chk(16'(gateResult_q), 16'h0000);
        @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk(16'(stateCode_q), 16'h0002);
        repeat (4) @(posedge clk);
        #1;
        // the reset cleared the configuration as well
        chk(16'(stateCode_q), 16'h0003);
        chk(16'(gateResult_q), 16'h0000);
        $display("mid-run reset test done");
        print_verdict();
    end
endmodule : tb_sag_gate
